// [bhw_map.vh]
// bhw_map.vh: offsets, banks, field positions and reset values of the banked host register window.
// assumes: included by bhw_window.v only; offsets are byte offsets inside the sixteen-byte window.
`ifndef BHW_MAP_VH
`define BHW_MAP_VH

`define BHW_WIN_BYTES 16
`define BHW_OFF_BANK_SEL 4'hE

`define BHW_BANK_HOST 16'h0000
`define BHW_BANK_STATION 16'h0002
`define BHW_BANK_CORE 16'h0003
`define BHW_BANK_QUEUE 16'h0011

`define BHW_OFF_BASE_ADDR 4'h0
`define BHW_OFF_RX_WMARK 4'h4
`define BHW_OFF_FAULT 4'h6
`define BHW_OFF_BURST 4'h8
`define BHW_OFF_MAC_LO 4'h0
`define BHW_OFF_MAC_MID 4'h2
`define BHW_OFF_MAC_HI 4'h4
`define BHW_OFF_ICTRL 4'h0
`define BHW_OFF_BIST 4'h4
`define BHW_OFF_GRST 4'h6
`define BHW_OFF_SETUP 4'h8
`define BHW_OFF_Q_LEVEL 4'h0
`define BHW_OFF_Q_DATA_LO 4'h8
`define BHW_OFF_Q_DATA_HI 4'hA
`define BHW_WORD_Q_DATA 2'h2

`define BHW_FAULT_UNMAPPED 0
`define BHW_FAULT_OVERFLOW 1
`define BHW_GRST_FLUSH 0

`define BHW_RST_REG16 16'h0000
`define BHW_RST_BANK 16'h0000
`define BHW_BIST_PASS 16'h0000

`define BHW_FIFO_WIDTH 32
`define BHW_FIFO_DEPTH 16

`endif

// [bhw_window.v]
// bhw_window.v: banked sixteen-byte host register window with a packet data FIFO toward the core.
// assumes: host strobes, address, lanes and data are asynchronous pins held stable across each strobe;
// the core drains packet words with valid/ready on clk_sys_in.
`timescale 1ns/1ps
`include "bhw_map.vh"

module bhw_fifo #(
  parameter WIDTH = `BHW_FIFO_WIDTH,
  parameter DEPTH = `BHW_FIFO_DEPTH,
  parameter AW = 4
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire flush_in,
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  output reg out_valid_out,
  output reg [WIDTH-1:0] out_data_out,
  input wire out_ready_in,
  output wire [AW:0] level_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // the output stage counts as one more slot, so level can reach DEPTH+1
  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign push = in_valid_in & in_ready_out;
  assign pop = (count_r != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);
  assign level_out = count_r + {{AW{1'b0}}, out_valid_out};

  always @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end else if (flush_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
        out_data_out <= mem[rd_ptr_r];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // bhw_fifo

module bhw_window #(
  parameter FIFO_WIDTH = `BHW_FIFO_WIDTH,
  parameter FIFO_DEPTH = `BHW_FIFO_DEPTH,
  parameter [15:0] BIST_RESULT = `BHW_BIST_PASS
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire cs_n_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire [3:0] addr_in,
  input wire [3:0] byte_lane_enables_n_in,
  input wire [31:0] data_in,
  output reg [31:0] data_out,
  output reg data_oe_out,
  output reg host_ready_out,
  output wire pkt_valid_out,
  output wire [31:0] pkt_data_out,
  input wire pkt_ready_in,
  output reg [31:0] station_address_out,
  output reg [15:0] station_address_high_out,
  output reg [15:0] internal_bus_control_out,
  output reg [15:0] host_bus_setup_out
);
  // two-stage synchronisers; stage one feeds stage two only
  reg [45:0] sync1_r;
  reg [45:0] sync2_r;
  reg rd_prev_r;
  reg wr_prev_r;

  reg [15:0] bank_r;
  reg [15:0] base_addr_r;
  reg [15:0] rx_wmark_r;
  reg [15:0] fault_r;
  reg [15:0] burst_r;
  reg [15:0] mac_lo_r;
  reg [15:0] mac_mid_r;
  reg [15:0] mac_hi_r;
  reg [15:0] ictrl_r;
  reg [15:0] grst_r;
  reg [15:0] setup_r;

  wire cs_s = sync2_r[45];
  wire rd_s = sync2_r[44];
  wire wr_s = sync2_r[43];
  wire [3:0] a_s = sync2_r[42:39];
  wire [3:0] be_s = sync2_r[38:35];
  wire [31:0] d_s = sync2_r[34:3];
  wire rd_act = ~cs_s & ~rd_s;
  wire wr_act = ~cs_s & ~wr_s;
  wire rd_go = rd_act & ~rd_prev_r;
  wire wr_go = wr_act & ~wr_prev_r;

  // each 32-bit word is two 16-bit halves; half k owns lanes 2k and 2k+1
  wire [3:0] off0 = {a_s[3:2], 2'b00};
  wire [3:0] off1 = {a_s[3:2], 2'b10};
  wire [3:0] lane_on = ~be_s;

  wire fifo_in_ready;
  wire [4:0] fifo_level;
  wire push = wr_go & (bank_r == `BHW_BANK_QUEUE) & (a_s[3:2] == `BHW_WORD_Q_DATA) & (|lane_on);
  wire flush = grst_r[`BHW_GRST_FLUSH];
  wire [31:0] push_data = {{8{lane_on[3]}}, {8{lane_on[2]}}, {8{lane_on[1]}}, {8{lane_on[0]}}} & d_s;

  // which locations hold a register in the active bank
  function mapped;
    input [15:0] bk;
    input [3:0] off;
    begin
      mapped = 1'b0;
      if (off == `BHW_OFF_BANK_SEL) begin
        mapped = 1'b1;
      end else begin
        case (bk)
          `BHW_BANK_HOST: mapped = (off == `BHW_OFF_BASE_ADDR) | (off == `BHW_OFF_RX_WMARK) |
            (off == `BHW_OFF_FAULT) | (off == `BHW_OFF_BURST);
          `BHW_BANK_STATION: mapped = (off == `BHW_OFF_MAC_LO) | (off == `BHW_OFF_MAC_MID) |
            (off == `BHW_OFF_MAC_HI);
          `BHW_BANK_CORE: mapped = (off == `BHW_OFF_ICTRL) | (off == `BHW_OFF_BIST) |
            (off == `BHW_OFF_GRST) | (off == `BHW_OFF_SETUP);
          `BHW_BANK_QUEUE: mapped = (off == `BHW_OFF_Q_LEVEL) | (off == `BHW_OFF_Q_DATA_LO) |
            (off == `BHW_OFF_Q_DATA_HI);
          default: mapped = 1'b0;
        endcase
      end
    end
  endfunction

  // read value of one 16-bit location; anything unassigned reads zero
  function [15:0] rd_half;
    input [15:0] bk;
    input [3:0] off;
    begin
      rd_half = 16'h0000;
      if (off == `BHW_OFF_BANK_SEL) begin
        rd_half = bank_r;
      end else begin
        case (bk)
          `BHW_BANK_HOST: begin
            if (off == `BHW_OFF_BASE_ADDR) rd_half = base_addr_r;
            if (off == `BHW_OFF_RX_WMARK) rd_half = rx_wmark_r;
            if (off == `BHW_OFF_FAULT) rd_half = fault_r;
            if (off == `BHW_OFF_BURST) rd_half = burst_r;
          end
          `BHW_BANK_STATION: begin
            if (off == `BHW_OFF_MAC_LO) rd_half = mac_lo_r;
            if (off == `BHW_OFF_MAC_MID) rd_half = mac_mid_r;
            if (off == `BHW_OFF_MAC_HI) rd_half = mac_hi_r;
          end
          `BHW_BANK_CORE: begin
            if (off == `BHW_OFF_ICTRL) rd_half = ictrl_r;
            if (off == `BHW_OFF_BIST) rd_half = BIST_RESULT;
            if (off == `BHW_OFF_GRST) rd_half = grst_r;
            if (off == `BHW_OFF_SETUP) rd_half = setup_r;
          end
          `BHW_BANK_QUEUE: begin
            if (off == `BHW_OFF_Q_LEVEL) rd_half = {11'h000, fifo_level};
          end
          default: rd_half = 16'h0000;
        endcase
      end
    end
  endfunction

  // merge enabled lanes of a write into one register; every host width lands on the same bank/offset
  function [15:0] upd;
    input [15:0] old;
    input [15:0] bk;
    input [3:0] off;
    input any_bank;
    reg hit_bank;
    begin
      hit_bank = any_bank | (bank_r == bk);
      upd = old;
      if (wr_go & hit_bank & (off0 == off)) begin
        if (lane_on[0]) upd[7:0] = d_s[7:0];
        if (lane_on[1]) upd[15:8] = d_s[15:8];
      end
      if (wr_go & hit_bank & (off1 == off)) begin
        if (lane_on[2]) upd[7:0] = d_s[23:16];
        if (lane_on[3]) upd[15:8] = d_s[31:24];
      end
    end
  endfunction

  wire miss0 = (lane_on[0] | lane_on[1]) & ~mapped(bank_r, off0);
  wire miss1 = (lane_on[2] | lane_on[3]) & ~mapped(bank_r, off1);
  wire [15:0] fault_set;
  assign fault_set[`BHW_FAULT_UNMAPPED] = (wr_go | rd_go) & (miss0 | miss1);
  assign fault_set[`BHW_FAULT_OVERFLOW] = push & ~fifo_in_ready;
  assign fault_set[15:2] = 14'h0000;

  wire [15:0] rd0 = rd_half(bank_r, off0);
  wire [15:0] rd1 = rd_half(bank_r, off1);
  wire [31:0] rd_word = {{8{lane_on[3]}}, {8{lane_on[2]}}, {8{lane_on[1]}}, {8{lane_on[0]}}} & {rd1, rd0};

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // idle strobe and lane levels, so no false access edge follows reset
      sync1_r <= {3'b111, 4'h0, 4'hF, 32'h00000000, 3'b000};
      sync2_r <= {3'b111, 4'h0, 4'hF, 32'h00000000, 3'b000};
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      sync1_r <= {cs_n_in, rd_n_in, wr_n_in, addr_in, byte_lane_enables_n_in, data_in, 3'b000};
      sync2_r <= sync1_r;
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
    end
  end

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_r <= `BHW_RST_BANK;
      base_addr_r <= `BHW_RST_REG16;
      rx_wmark_r <= `BHW_RST_REG16;
      fault_r <= `BHW_RST_REG16;
      burst_r <= `BHW_RST_REG16;
      mac_lo_r <= `BHW_RST_REG16;
      mac_mid_r <= `BHW_RST_REG16;
      mac_hi_r <= `BHW_RST_REG16;
      ictrl_r <= `BHW_RST_REG16;
      grst_r <= `BHW_RST_REG16;
      setup_r <= `BHW_RST_REG16;
    end else begin
      bank_r <= upd(bank_r, `BHW_RST_BANK, `BHW_OFF_BANK_SEL, 1'b1);
      base_addr_r <= upd(base_addr_r, `BHW_BANK_HOST, `BHW_OFF_BASE_ADDR, 1'b0);
      rx_wmark_r <= upd(rx_wmark_r, `BHW_BANK_HOST, `BHW_OFF_RX_WMARK, 1'b0);
      burst_r <= upd(burst_r, `BHW_BANK_HOST, `BHW_OFF_BURST, 1'b0);
      mac_lo_r <= upd(mac_lo_r, `BHW_BANK_STATION, `BHW_OFF_MAC_LO, 1'b0);
      mac_mid_r <= upd(mac_mid_r, `BHW_BANK_STATION, `BHW_OFF_MAC_MID, 1'b0);
      mac_hi_r <= upd(mac_hi_r, `BHW_BANK_STATION, `BHW_OFF_MAC_HI, 1'b0);
      ictrl_r <= upd(ictrl_r, `BHW_BANK_CORE, `BHW_OFF_ICTRL, 1'b0);
      grst_r <= upd(grst_r, `BHW_BANK_CORE, `BHW_OFF_GRST, 1'b0);
      setup_r <= upd(setup_r, `BHW_BANK_CORE, `BHW_OFF_SETUP, 1'b0);
      // sticky faults; a new fault in the clearing cycle still lands
      fault_r <= (fault_r & {16{~flush}}) | fault_set;
    end
  end

  // read data is captured once at the strobe edge, so a slow host sees a stable word
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_out <= 32'h00000000;
      data_oe_out <= 1'b0;
      host_ready_out <= 1'b0;
      station_address_out <= 32'h00000000;
      station_address_high_out <= 16'h0000;
      internal_bus_control_out <= 16'h0000;
      host_bus_setup_out <= 16'h0000;
    end else begin
      if (rd_go) begin
        data_out <= rd_word;
      end
      data_oe_out <= rd_act;
      host_ready_out <= fifo_in_ready & ~flush;
      station_address_out <= {mac_mid_r, mac_lo_r};
      station_address_high_out <= mac_hi_r;
      internal_bus_control_out <= ictrl_r;
      host_bus_setup_out <= setup_r;
    end
  end

  // a full FIFO drops the word and flags overflow; the host has no wait line beyond host_ready_out
  bhw_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .flush_in(flush),
    .in_valid_in(push),
    .in_data_in(push_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(pkt_valid_out),
    .out_data_out(pkt_data_out),
    .out_ready_in(pkt_ready_in),
    .level_out(fifo_level)
  );
endmodule // bhw_window

// [bhw_window_properties.sv]
// bhw_window_properties.sv: port-level checker for the banked host register window.
// assumes: host pins are moved just after a clock edge and held while the strobe is low.
`timescale 1ns/1ps
module bhw_window_chk (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [3:0] byte_lane_enables_n_in,
  input wire logic [31:0] data_out,
  input wire logic data_oe_out,
  input wire logic pkt_valid_out,
  input wire logic [31:0] pkt_data_out,
  input wire logic pkt_ready_in,
  input wire logic [31:0] station_address_out,
  input wire logic [15:0] station_address_high_out,
  input wire logic [15:0] internal_bus_control_out,
  input wire logic [15:0] host_bus_setup_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // lanes that the host left disabled must come back as zero
  wire [31:0] lane_mask = {{8{~byte_lane_enables_n_in[3]}}, {8{~byte_lane_enables_n_in[2]}},
    {8{~byte_lane_enables_n_in[1]}}, {8{~byte_lane_enables_n_in[0]}}};
  sequence s_rd_start; !cs_n_in && $fell(rd_n_in) && wr_n_in; endsequence
  sequence s_oe_up; $rose(data_oe_out); endsequence
  sequence s_wr_held; !cs_n_in && !wr_n_in; endsequence
  property p_rd_answer; s_rd_start |-> ##[1:3] data_oe_out; endproperty
  property p_oe_release; $rose(rd_n_in) |-> ##[1:4] !data_oe_out; endproperty
  property p_oe_cause; s_oe_up |-> !cs_n_in && !rd_n_in; endproperty
  property p_lanes; s_oe_up |-> (data_out & ~lane_mask) == 32'h00000000; endproperty
  property p_pkt_hold; pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_data_out); endproperty
  property p_sta; $changed(station_address_out) |-> s_wr_held; endproperty
  property p_stah; $changed(station_address_high_out) |-> s_wr_held; endproperty
  property p_ictl; $changed(internal_bus_control_out) |-> s_wr_held; endproperty
  property p_setup; $changed(host_bus_setup_out) |-> s_wr_held; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered");
  a_oe_release: assert property (p_oe_release) else $error("data bus not released");
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  a_lanes: assert property (p_lanes) else $error("disabled lane not zero");
  a_pkt_hold: assert property (p_pkt_hold) else $error("packet word dropped while stalled");
  a_sta: assert property (p_sta) else $error("station word changed without write");
  a_stah: assert property (p_stah) else $error("station high changed without write");
  a_ictl: assert property (p_ictl) else $error("bus control changed without write");
  a_setup: assert property (p_setup) else $error("bus setup changed without write");
endmodule // bhw_window_chk
bind bhw_window bhw_window_chk u_bhw_window_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .byte_lane_enables_n_in(byte_lane_enables_n_in),
  .data_out(data_out), .data_oe_out(data_oe_out), .pkt_valid_out(pkt_valid_out), .pkt_data_out(pkt_data_out),
  .pkt_ready_in(pkt_ready_in), .station_address_out(station_address_out),
  .station_address_high_out(station_address_high_out), .internal_bus_control_out(internal_bus_control_out),
  .host_bus_setup_out(host_bus_setup_out));

// [bhw_core_sink.sv]
// bhw_core_sink.sv: core-side consumer of packet words, stalls on request or at random.
// assumes: one clock shared with the window; the bench owns the stall control.
`timescale 1ns/1ps
module bhw_core_sink (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  output logic pkt_ready_out
);
  // random gaps so the output stage is held as well as drained
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) pkt_ready_out <= 1'b0;
    else pkt_ready_out <= !stall_in && ($urandom % 3 != 0);
  end
endmodule // bhw_core_sink

// [test_bhw_window.sv]
// test_bhw_window.sv: self-checking bench for the banked host register window.
// assumes: bhw_window and bhw_core_sink compiled before this file.
`timescale 1ns/1ps
module test_bhw_window;
  logic clk = 0, rst_n = 0, cs_n = 1, rd_n = 1, wr_n = 1, stall = 1, pkt_ready, oe_q = 0;
  logic [3:0] addr = 4'h0, ben = 4'hF;
  logic [31:0] din = 32'h0, w, w2;
  logic [31:0] rdq[$], pktq[$];
  wire [31:0] dout, pdata, sta;
  wire [15:0] stah, ictl, setup;
  wire oe, hrdy, pval;
  int fails = 0, cmp_count = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  bhw_window u_bhw_window (.clk_sys_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_in(addr), .byte_lane_enables_n_in(ben), .data_in(din), .data_out(dout), .data_oe_out(oe),
    .host_ready_out(hrdy), .pkt_valid_out(pval), .pkt_data_out(pdata), .pkt_ready_in(pkt_ready),
    .station_address_out(sta), .station_address_high_out(stah), .internal_bus_control_out(ictl),
    .host_bus_setup_out(setup));
  bhw_core_sink u_bhw_core_sink (.clk_sys_in(clk), .rst_n_in(rst_n), .stall_in(stall), .pkt_ready_out(pkt_ready));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a result that nobody expected is a mismatch by itself, never a compare against X
  task stray;
    fails++;
    $display("wrong value at %0t: result with no expectation", $time);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // strobe held 5 cycles, idle 4: the synchroniser needs 3 each way
  task hacc(input logic wr, input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    addr <= a; ben <= b; din <= d; cs_n <= 1'b0; rd_n <= wr; wr_n <= !wr;
    repeat (5) @(posedge clk);
    cs_n <= 1'b1; rd_n <= 1'b1; wr_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [3:0] b, input logic [31:0] e);
    rdq.push_back(e);
    hacc(1'b0, a, b, 32'h0);
  endtask
  task sel(input logic [15:0] k);
    hacc(1'b1, 4'hE, 4'h3, {k, 16'h0000});
  endtask
  // result watcher: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    oe_q <= oe;
    cyc <= cyc + 1;
    if (oe && !oe_q) begin
      if (rdq.size() > 0) chk(dout, rdq.pop_front());
      else stray;
    end
    if (pval && pkt_ready) begin
      if (pktq.size() > 0) chk(pdata, pktq.pop_front());
      else stray;
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'hCEDD));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    w = $urandom;
    sel(16'h0000); hacc(1'b1, 4'h0, 4'h0, w);
    rd(4'h0, 4'h0, {16'h0000, w[15:0]});
    hacc(1'b1, 4'h4, 4'hC, w);
    hacc(1'b1, 4'h8, 4'hC, ~w);
    rd(4'h4, 4'hC, {16'h0000, w[15:0]});
    rd(4'h8, 4'hC, {16'h0000, ~w[15:0]});
    sel(16'h0002); hacc(1'b1, 4'h0, 4'h0, w);
    chk(sta, w);
    hacc(1'b1, 4'h1, 4'hD, 32'h0000A500);
    w2 = {w[31:16], 8'hA5, w[7:0]};
    chk(sta, w2);
    rd(4'h0, 4'h0, w2); rd(4'h2, 4'hB, {8'h00, w2[23:16], 16'h0000});
    w2 = ~w;
    hacc(1'b1, 4'h4, 4'h0, w2);
    chk(stah, w2[15:0]);
    sel(16'h0003); hacc(1'b1, 4'h0, 4'h0, w);
    chk(ictl, w[15:0]);
    hacc(1'b1, 4'h8, 4'hC, w2);
    chk(setup, w2[15:0]);
    hacc(1'b1, 4'h4, 4'hC, w);
    rd(4'h4, 4'h0, 32'h0); rd(4'h8, 4'h0, {16'h0000, w2[15:0]});
    sel(16'h0005); hacc(1'b1, 4'h0, 4'h0, w);
    rd(4'h0, 4'h0, 32'h0); rd(4'hE, 4'h3, {16'h0005, 16'h0000});
    // core stalled: 16 stored plus the output stage, the 18th word is refused
    sel(16'h0011);
    for (int i = 0; i < 18; i++) begin
      w = $urandom;
      if (i < 17) pktq.push_back(w);
      hacc(1'b1, 4'h8, 4'h0, w);
    end
    chk(hrdy, 32'h0);
    rd(4'h0, 4'hC, {16'h0000, 16'h0011});
    sel(16'h0000); rd(4'h4, 4'h3, {16'h0003, 16'h0000});
    stall <= 1'b0;
    for (int i = 0; i < 400 && pktq.size() > 0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(pktq.size(), 32'h0);
    chk(hrdy, 32'h1);
    // flush: refuses packet words and clears the sticky faults while set
    sel(16'h0003); hacc(1'b1, 4'h4, 4'h3, 32'h00010000);
    chk(hrdy, 32'h0);
    sel(16'h0000); rd(4'h4, 4'h3, 32'h0);
    sel(16'h0003); hacc(1'b1, 4'h4, 4'h3, 32'h0);
    rd(4'h4, 4'h3, 32'h0);
    chk(hrdy, 32'h1);
    tally_and_finish;
  end
endmodule // test_bhw_window
